// ===== fcs_flash_config_status_regs.sv
// Flash configuration and protection/wait-state status register bank
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

module fcs_flash_config_status_regs #(
    parameter int SETTLE_CYCLES = fcs_pkg::WAIT_SETTLE_CYCLES
) (
    input  wire logic                      mclk,
    input  wire logic                      reset_n,
    // Register port
    input  wire logic [fcs_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [fcs_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic      [fcs_pkg::DATA_W-1:0] reg_rdata,
    // Flash controller side
    input  wire logic                      command_done_flag,
    input  wire logic                      override_active,
    input  wire logic                      array_read_busy,
    input  wire logic                      lock_load,
    input  wire logic [1:0]                lock_load_value,
    input  wire logic                      step_done,
    input  wire logic                      verify_failed,
    // Erase all request pin from the system
    input  wire logic                      erase_all_req_pin,
    // Outputs
    output logic                           command_done_irq,
    output logic      [1:0]                active_wait_select,
    output logic                           wait_states_disabled,
    output logic                           single_fault_report_ignore,
    output logic                           force_double_fault,
    output logic                           force_single_fault,
    output logic                           seq_erase_all,
    output logic                           seq_verify,
    output logic                           seq_program_lock_byte,
    output logic      [1:0]                lock_state_field,
    output logic                           secured
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                 command_done_irq_enable;   // Interrupt enable
    logic [1:0]           wait_cycle_select;         // Requested wait select
    logic                 wait_switch_ack_flag;      // Switch complete
    logic                 erase_all_request_bit;     // Sequence running
    logic [1:0]           lock_state;                // Lock state field
    // 8 bits keep only the low byte of the settle count; no saturation at 255
    logic [7:0]           settle_count;              // Settle countdown
    logic                 req_meta;                  // Sync stage one
    logic                 req_sync;                  // Sync stage two
    logic                 req_served;                // Held request handled
    fcs_pkg::fcs_seq_t    seq_state;                 // Erase sequence state
    fcs_pkg::fcs_seq_t    next_seq_state;            // Next sequence state

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // One compare per mapped offset
    wire hit_status = (reg_addr == fcs_pkg::OFS_PROT_WAIT_STATUS);
    wire hit_config = (reg_addr == fcs_pkg::OFS_FLASH_CONFIG);
    wire cfg_write  = reg_write && hit_config;

    // Wait select only accepted while no command runs, else ignored
    wire [1:0] wdata_wait = reg_wdata[fcs_pkg::CFG_WAIT_SEL_HI:
                                      fcs_pkg::CFG_WAIT_SEL_LO];
    wire wait_change = cfg_write && command_done_flag &&
                       (wdata_wait != wait_cycle_select);

    // Switch may land once settled and no array read is in flight
    wire switch_ready = !wait_switch_ack_flag && (settle_count == 8'h00) &&
                        !array_read_busy;

    // ------------------------------------------------------------------
    // Read data assembly
    // ------------------------------------------------------------------
    // Bits 6..1 are unused, read 0
    wire [7:0] status_value = {
        override_active,
        6'h00,
        wait_switch_ack_flag
    };

    // Bit 5 shows the running request
    wire [7:0] config_value = {
        command_done_irq_enable,
        1'b0,
        erase_all_request_bit,
        single_fault_report_ignore,
        wait_cycle_select,
        force_double_fault,
        force_single_fault
    };

    // Unmapped offsets read as zero
    wire [7:0] read_mux = hit_status ? status_value :
                          hit_config ? config_value : 8'h00;

    // ------------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------------
    // Data stands only in the cycle after the strobe; zero otherwise
    // Reads leave every field untouched
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= read_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------
    // Status writes fall through untouched; the request bit has no
    // write path here at all
    // Bit 6 has no flop behind it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            command_done_irq_enable    <=
                fcs_pkg::CONFIG_RESET[fcs_pkg::CFG_IRQ_EN_BIT];
            single_fault_report_ignore <=
                fcs_pkg::CONFIG_RESET[fcs_pkg::CFG_IGNORE_SF_BIT];
            force_double_fault         <=
                fcs_pkg::CONFIG_RESET[fcs_pkg::CFG_FORCE_DF_BIT];
            force_single_fault         <=
                fcs_pkg::CONFIG_RESET[fcs_pkg::CFG_FORCE_SF_BIT];
        end else if (cfg_write) begin
            command_done_irq_enable    <=
                reg_wdata[fcs_pkg::CFG_IRQ_EN_BIT];
            single_fault_report_ignore <=
                reg_wdata[fcs_pkg::CFG_IGNORE_SF_BIT];
            force_double_fault         <=
                reg_wdata[fcs_pkg::CFG_FORCE_DF_BIT];
            force_single_fault         <=
                reg_wdata[fcs_pkg::CFG_FORCE_SF_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Wait select field and switch handshake
    // ------------------------------------------------------------------
    // A write while busy leaves the field
    // Reserved codes read back as written; the active path takes them over
    // unchanged, with wait states left enabled
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wait_cycle_select <= fcs_pkg::WAIT_SEL_MAX;
        end else if (wait_change) begin
            wait_cycle_select <= wdata_wait;
        end
    end

    // A fresh change restarts the settle wait, so a later request
    // always beats the acknowledge of an earlier one
    // Count rests at zero once run down
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            settle_count <= 8'h00;
        end else if (wait_change) begin
            settle_count <= 8'(SETTLE_CYCLES);
        end else if (settle_count != 8'h00) begin
            settle_count <= settle_count - 8'h01;
        end
    end

    // Acknowledge drops on an accepted wait select change and rises in the cycle the new
    // setting takes over the array read path
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wait_switch_ack_flag <= fcs_pkg::WAIT_ACK_RESET;
        end else if (wait_change) begin
            wait_switch_ack_flag <= 1'b0;
        end else if (switch_ready) begin
            wait_switch_ack_flag <= 1'b1;
        end
    end

    // Active setting seen by the read path; old value held meanwhile.
    // Software must see the acknowledge before touching the clock.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            active_wait_select   <= fcs_pkg::WAIT_SEL_MAX;
            wait_states_disabled <= 1'b0;
        end else if (switch_ready) begin
            active_wait_select   <= wait_cycle_select;
            wait_states_disabled <=
                (wait_cycle_select == fcs_pkg::WAIT_SEL_OFF);
        end
    end

    // ------------------------------------------------------------------
    // Erase all request pin synchroniser
    // ------------------------------------------------------------------
    // Async pin: two flops before use
    // Only the second flop is read
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
        end else begin
            req_meta <= erase_all_req_pin;
            req_sync <= req_meta;
        end
    end

    // A held pin starts one sequence only; it must drop to re-arm
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            req_served <= 1'b0;
        end else if (!req_sync) begin
            req_served <= 1'b0;
        end else if (seq_state == fcs_pkg::FCS_SEQ_ERASE) begin
            req_served <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Erase all sequence
    // ------------------------------------------------------------------
    wire seq_start = (seq_state == fcs_pkg::FCS_SEQ_IDLE) && req_sync &&
                     !req_served && command_done_flag;

    // Steps advance on the controller's completion pulse; a failed
    // verify ends the run without releasing the lock
    // Steps never skip; erase, verify and program each wait their pulse, unsecure does not
    always_comb begin
        next_seq_state = seq_state;
        case (seq_state)
            fcs_pkg::FCS_SEQ_IDLE: begin
                if (seq_start) begin
                    next_seq_state = fcs_pkg::FCS_SEQ_ERASE;
                end
            end
            fcs_pkg::FCS_SEQ_ERASE: begin
                if (step_done) begin
                    next_seq_state = fcs_pkg::FCS_SEQ_VERIFY;
                end
            end
            fcs_pkg::FCS_SEQ_VERIFY: begin
                if (step_done && verify_failed) begin
                    next_seq_state = fcs_pkg::FCS_SEQ_IDLE;
                end else if (step_done) begin
                    next_seq_state = fcs_pkg::FCS_SEQ_PROGRAM;
                end
            end
            fcs_pkg::FCS_SEQ_PROGRAM: begin
                if (step_done) begin
                    next_seq_state = fcs_pkg::FCS_SEQ_UNSECURE;
                end
            end
            fcs_pkg::FCS_SEQ_UNSECURE: begin
                next_seq_state = fcs_pkg::FCS_SEQ_IDLE;
            end
            default: begin
                next_seq_state = fcs_pkg::FCS_SEQ_IDLE;
            end
        endcase
    end

    // State register
    // Only idle listens to the pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seq_state <= fcs_pkg::FCS_SEQ_IDLE;
        end else begin
            seq_state <= next_seq_state;
        end
    end

    // Request bit follows the run: set on start, cleared on the way out
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            erase_all_request_bit <= 1'b0;
        end else if (seq_start) begin
            erase_all_request_bit <= 1'b1;
        end else if (next_seq_state == fcs_pkg::FCS_SEQ_IDLE) begin
            erase_all_request_bit <= 1'b0;
        end
    end

    // Step outputs are registered copies of the next state
    // so the controller sees clean levels
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seq_erase_all         <= 1'b0;
            seq_verify            <= 1'b0;
            seq_program_lock_byte <= 1'b0;
        end else begin
            seq_erase_all         <=
                (next_seq_state == fcs_pkg::FCS_SEQ_ERASE);
            seq_verify            <=
                (next_seq_state == fcs_pkg::FCS_SEQ_VERIFY);
            seq_program_lock_byte <=
                (next_seq_state == fcs_pkg::FCS_SEQ_PROGRAM);
        end
    end

    // ------------------------------------------------------------------
    // Lock state field
    // ------------------------------------------------------------------
    // Stays secured from reset until the controller loads the stored
    // byte; a release always lands on the unsecure code
    // Release beats a load in one cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lock_state <= fcs_pkg::LOCK_RESET;
        end else if (seq_state == fcs_pkg::FCS_SEQ_UNSECURE) begin
            lock_state <= fcs_pkg::LOCK_UNSECURE;
        end else if (lock_load) begin
            lock_state <= lock_load_value;
        end
    end

    // Field and flag from the register
    assign lock_state_field = lock_state;
    assign secured          = (lock_state != fcs_pkg::LOCK_UNSECURE);

    // ------------------------------------------------------------------
    // Command complete interrupt
    // ------------------------------------------------------------------
    // Level request, follows the done flag in the same cycle
    // No latch: either input drops it
    assign command_done_irq = command_done_irq_enable &&
                              command_done_flag;

endmodule

// ===== fcs_pkg.sv
// Shared constants for the flash configuration and status register bank
package fcs_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;                      // Register address width
    localparam int DATA_W = 8;                      // Register data width

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PROT_WAIT_STATUS = 8'h03;  // Status, read only
    localparam logic [7:0] OFS_FLASH_CONFIG     = 8'h04;  // Configuration

    // ------------------------------------------------------------------
    // Status register field positions
    // ------------------------------------------------------------------
    localparam int STS_OVERRIDE_BIT = 7;            // Override active flag
    localparam int STS_WAIT_ACK_BIT = 0;            // Wait switch acknowledge

    // ------------------------------------------------------------------
    // Configuration register field positions
    // ------------------------------------------------------------------
    localparam int CFG_IRQ_EN_BIT    = 7;           // Command done irq enable
    localparam int CFG_ERASE_REQ_BIT = 5;           // Erase all request, RO
    localparam int CFG_IGNORE_SF_BIT = 4;           // Ignore single faults
    localparam int CFG_WAIT_SEL_HI   = 3;           // Wait select, high bit
    localparam int CFG_WAIT_SEL_LO   = 2;           // Wait select, low bit
    localparam int CFG_FORCE_DF_BIT  = 1;           // Force double fault
    localparam int CFG_FORCE_SF_BIT  = 0;           // Force single fault

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] WAIT_SEL_MAX      = 2'h0; // Max wait cycles
    localparam logic [1:0] WAIT_SEL_OFF      = 2'h3; // Wait states disabled
    localparam logic [1:0] LOCK_UNSECURE     = 2'h2; // Unsecured encoding
    localparam logic [1:0] LOCK_RESET        = 2'h3; // Secured until loaded
    localparam logic       WAIT_ACK_RESET    = 1'b1; // Reset setting in force
    localparam logic [7:0] CONFIG_RESET      = 8'h00; // Writable fields reset

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 100;       // mclk period
    localparam int WAIT_SETTLE_TIME_NS = 200;       // Least settle before switch
    localparam int WAIT_SETTLE_CYCLES  =            // Rounded up, at least one
        (WAIT_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (WAIT_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Erase all sequence states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FCS_SEQ_IDLE,
        FCS_SEQ_ERASE,
        FCS_SEQ_VERIFY,
        FCS_SEQ_PROGRAM,
        FCS_SEQ_UNSECURE
    } fcs_seq_t;

endpackage

// ===== fcs_regs_monitor.sv
// Concurrent checks on the ports of the flash config/status register bank
`timescale 1ns/1ps
module fcs_regs_monitor #(
    parameter int SETTLE_CYCLES = 2
) (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       command_done_flag,
    input wire logic       override_active,
    input wire logic       array_read_busy,
    input wire logic       lock_load,
    input wire logic [1:0] lock_load_value,
    input wire logic       step_done,
    input wire logic       verify_failed,
    input wire logic       erase_all_req_pin,
    input wire logic       command_done_irq,
    input wire logic [1:0] active_wait_select,
    input wire logic       wait_states_disabled,
    input wire logic       single_fault_report_ignore,
    input wire logic       force_double_fault,
    input wire logic       force_single_fault,
    input wire logic       seq_erase_all,
    input wire logic       seq_verify,
    input wire logic       seq_program_lock_byte,
    input wire logic [1:0] lock_state_field,
    input wire logic       secured
);
    // ------------------------------------------------------------------
    // Helpers and defaults
    // ------------------------------------------------------------------
    wire cfg_wr = reg_write && (reg_addr == fcs_pkg::OFS_FLASH_CONFIG);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    irq_gate_a: assert property (command_done_irq |-> command_done_flag)
        else $error("irq high without done flag");
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    status_read_a: assert property ($past(reg_read) && $past(reg_addr) == 8'h03
        |-> reg_rdata[6:1] == 6'h00 && reg_rdata[7] == $past(override_active))
        else $error("status read value wrong");
    cfg_reserved_a: assert property ($past(reg_read) && $past(reg_addr) == 8'h04
        |-> !reg_rdata[6]) else $error("config bit 6 not zero");
    wait_hold_a: assert property ($changed(active_wait_select)
        |-> !$past(array_read_busy)) else $error("wait switch during read");
    wait_settle_a: assert property (cfg_wr
        |-> ##SETTLE_CYCLES $stable(active_wait_select))
        else $error("wait switch too early");
    wait_off_a: assert property (wait_states_disabled ==
        (active_wait_select == fcs_pkg::WAIT_SEL_OFF))
        else $error("wait disable flag wrong");
    erase_start_a: assert property ($rose(seq_erase_all)
        |-> $past(command_done_flag)) else $error("erase began while busy");
    step_order_a: assert property (($rose(seq_verify) |-> $past(seq_erase_all))
        and ($rose(seq_program_lock_byte) |-> $past(seq_verify)))
        else $error("erase steps out of order");
    unsecure_lock_a: assert property ($fell(seq_program_lock_byte)
        |=> lock_state_field == fcs_pkg::LOCK_UNSECURE)
        else $error("lock field not released");
    secured_flag_a: assert property (secured ==
        (lock_state_field != fcs_pkg::LOCK_UNSECURE))
        else $error("secured flag wrong");

    // ------------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------------
    cover property ($rose(seq_erase_all));
    cover property ($changed(active_wait_select));
    cover property (command_done_irq);
    cover property ($fell(seq_program_lock_byte));
endmodule

// ===== fcs_ctrl_model.sv
// Behavioural flash controller answering the erase all sequence steps
`timescale 1ns/1ps
module fcs_ctrl_model (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       seq_erase_all,
    input  wire logic       seq_verify,
    input  wire logic       seq_program_lock_byte,
    input  wire logic       fail_verify,
    input  wire logic [3:0] step_delay,
    output logic            step_done,
    output logic            verify_failed
);
    logic [3:0] wait_cnt;   // Cycles spent in the current step
    wire        busy = seq_erase_all | seq_verify | seq_program_lock_byte;
    // Finish each step step_delay plus one cycles after it starts; slow delays stretch steps
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wait_cnt  <= 4'h0;
            step_done <= 1'b0;
        end else if (busy && !step_done && wait_cnt >= step_delay) begin
            wait_cnt  <= 4'h0;
            step_done <= 1'b1;
        end else begin
            wait_cnt  <= (busy && !step_done) ? wait_cnt + 4'h1 : 4'h0;
            step_done <= 1'b0;
        end
    end
    // Failure only reported inside the verify step
    assign verify_failed = fail_verify & seq_verify;
endmodule

// ===== test_flash_config_status_regs.sv
// Self-checking bench for the flash config/status register bank
`timescale 1ns/1ps
module test_flash_config_status_regs;
    localparam int SETTLE_CYCLES = 2;   // Default settle count
    logic       mclk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
    logic       command_done_flag = 1'b1, override_active = 1'b0;
    logic       array_read_busy = 1'b0, lock_load = 1'b0, fail_verify = 1'b0;
    logic       erase_all_req_pin = 1'b0, step_done, verify_failed;
    logic [1:0] lock_load_value = 2'h0, active_wait_select, lock_state_field;
    logic [3:0] step_delay = 4'h1;
    logic       command_done_irq, wait_states_disabled, secured, seq_verify;
    logic       single_fault_report_ignore, force_double_fault;
    logic       force_single_fault, seq_erase_all, seq_program_lock_byte;
    int         n_fail = 0, n_tests = 0, i;

    always #(fcs_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;

    fcs_flash_config_status_regs #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_dut (.*);

    fcs_ctrl_model u_ctrl (.*);

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic timeout_if(input bit hit);
        if (hit) begin
            n_fail++;
            give_verdict();
        end
    endtask
    // One-cycle strobes launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    // Software polls the acknowledge before touching the clock setup
    task automatic poll_ack();
        rd = 8'h00;
        for (i = 0; i < 20 && rd[0] !== 1'b1; i++) begin
            rdr(8'h03);
        end
        timeout_if(rd[0] !== 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdr(8'h03); chk("status rst", rd, 8'h01);
        rdr(8'h04); chk("config rst", rd, 8'h00);
        rdr(8'h10); chk("unmapped", rd, 8'h00);
        chk("lock rst", {6'h00, lock_state_field}, 8'h03);
        lock_load <= 1'b1;
        lock_load_value <= 2'h1;
        @(posedge mclk);
        lock_load <= 1'b0;
        @(posedge mclk);
        #1 chk("lock load", {6'h00, lock_state_field}, 8'h01);
    endtask
    task automatic t_status_ro();
        wr(8'h03, 8'hFF);
        rdr(8'h03); chk("status ro", rd, 8'h01);
        override_active <= 1'b1;
        rdr(8'h03); chk("override", rd, 8'h81);
        override_active <= 1'b0;
    endtask
    task automatic t_wait_switch();
        array_read_busy <= 1'b1;
        wr(8'h04, 8'hFF);
        rdr(8'h03); chk("ack clear", rd, 8'h00);
        repeat (6) @(posedge mclk);
        rdr(8'h03); chk("ack busy", rd, 8'h00);
        chk("old wait", {6'h00, active_wait_select}, 8'h00);
        array_read_busy <= 1'b0;
        poll_ack();
        chk("wait off", {6'h00, active_wait_select}, 8'h03);
        chk("disabled", {7'h00, wait_states_disabled}, 8'h01);
        rdr(8'h04); chk("config rw", rd, 8'h9F);
        chk("faults", {5'h00, single_fault_report_ignore, force_double_fault,
            force_single_fault}, 8'h07);
        wr(8'h04, 8'h97);
        poll_ack();
        chk("reserved", {7'h00, wait_states_disabled}, 8'h00);
        wr(8'h04, 8'h9F);
        poll_ack();
    endtask
    task automatic t_cfg_irq();
        command_done_flag <= 1'b0;
        wr(8'h04, 8'hC0);
        rdr(8'h04); chk("wait held", rd, 8'h8C);
        rdr(8'h03); chk("ack kept", rd, 8'h01);
        chk("irq idle", {7'h00, command_done_irq}, 8'h00);
        command_done_flag <= 1'b1;
        #1 chk("irq on", {7'h00, command_done_irq}, 8'h01);
        wr(8'h04, 8'h0C);
        #1 chk("irq off", {7'h00, command_done_irq}, 8'h00);
    endtask
    task automatic t_erase(input logic fail, input logic [3:0] dly,
                           input logic [1:0] exp_lock);
        fail_verify <= fail;
        step_delay <= dly;
        erase_all_req_pin <= 1'b1;
        for (i = 0; i < 10 && seq_erase_all !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        timeout_if(i == 10);
        command_done_flag <= 1'b0;
        if (dly > 4'h8) begin
            rdr(8'h04); chk("req set", rd, 8'h2C);
            wr(8'h04, 8'h0C);
            rdr(8'h04); chk("req ro", rd, 8'h2C);
        end
        for (i = 0; i < 300 && (seq_erase_all | seq_verify |
             seq_program_lock_byte) !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        timeout_if(i == 300);
        command_done_flag <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk("lock end", {6'h00, lock_state_field}, {6'h00, exp_lock});
        chk("secure", {7'h00, secured}, {7'h00, exp_lock != 2'h2});
        chk("no rerun", {7'h00, seq_erase_all}, 8'h00);
        rdr(8'h04); chk("req clear", rd, 8'h0C);
        erase_all_req_pin <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_status_ro();
        t_wait_switch();
        t_cfg_irq();
        t_erase(1'b1, 4'hC, 2'h1);
        t_erase(1'b0, 4'h1, 2'h2);
        give_verdict();
    end
    initial begin
        #5000000;
        timeout_if(1'b1);
    end
endmodule

bind fcs_flash_config_status_regs fcs_regs_monitor #(
    .SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (.*);
